// ### flash_status_pkg.sv
package flash_status_pkg;

	localparam int BIT_BUSY  = 0;
	localparam int BIT_LATCH = 1;
	localparam int BIT_BP_LO = 2;
	localparam int BIT_BP_HI = 5;
	localparam int BIT_FOUR  = 6;
	localparam int BIT_LOCK  = 7;

	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [5:0] NV_RESET     = 6'h00;

	localparam logic [7:0] OP_LATCH_SET    = 8'h06;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_ERASE_ALL_A  = 8'hc7;
	localparam logic [7:0] OP_ERASE_ALL_B  = 8'h60;

	localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
	localparam logic [2:0] ADDR_BYTES_4 = 3'h4;
	localparam logic [2:0] DATA_BYTES_1 = 3'h1;
	localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
	localparam logic [2:0] BIT_LAST     = 3'h7;

	localparam int         BLOCK_LSB   = 16;
	localparam logic [9:0] BLOCK_TOTAL = 10'h200;

	localparam int WE_OPS_N = 39;
	localparam logic [7:0] WE_OPS [WE_OPS_N] = '{
		8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'hd7, 8'h20, 8'h21, 8'h52,
		8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60, 8'h01, 8'h42, 8'h65, 8'h63, 8'h85,
		8'h83, 8'h64, 8'h62, 8'h15, 8'h18, 8'hc5, 8'hfb, 8'he1, 8'hfd, 8'he3,
		8'he4, 8'h2f, 8'ha6, 8'h91, 8'h7e, 8'h98, 8'he8, 8'h43, 8'h4a};

	localparam int ARRAY_OPS_N = 13;
	localparam logic [7:0] ARRAY_OPS [ARRAY_OPS_N] = '{
		8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'hd7, 8'h20, 8'h21, 8'h52,
		8'h5c, 8'hd8, 8'hdc};

	localparam int ADDR4_OPS_N = 6;
	localparam logic [7:0] ADDR4_OPS [ADDR4_OPS_N] = '{
		8'h12, 8'h34, 8'h3e, 8'h21, 8'h5c, 8'hdc};

	function automatic logic in_we_set(input logic [7:0] op);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < WE_OPS_N; i++) hit = hit | (WE_OPS[i] == op);
		return hit;
	endfunction

	function automatic logic in_array_set(input logic [7:0] op);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < ARRAY_OPS_N; i++) hit = hit | (ARRAY_OPS[i] == op);
		return hit;
	endfunction

	function automatic logic in_addr4_set(input logic [7:0] op);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < ADDR4_OPS_N; i++) hit = hit | (ADDR4_OPS[i] == op);
		return hit;
	endfunction

	// Number of 64KB blocks covered by a protect pattern.
	function automatic logic [9:0] protect_count(input logic [3:0] bp);
		logic [9:0] n;
		case (bp)
			4'h0:    n = 10'h000;
			4'ha:    n = 10'h180;
			4'hb:    n = 10'h1c0;
			4'hc:    n = 10'h1e0;
			4'hd:    n = 10'h1f0;
			4'he:    n = 10'h1f8;
			4'hf:    n = 10'h200;
			default: n = 10'h001 << (bp - 4'h1);
		endcase
		return n;
	endfunction

	typedef enum logic [1:0] {
		FR_IDLE = 2'b00,
		FR_CMD  = 2'b01,
		FR_READ = 2'b11,
		FR_DROP = 2'b10
	} frame_t;

endpackage

// ### spi_front.sv
`timescale 1ns/1ps
module spi_front (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic       si,
	input  wire logic       wp_n,
	output logic            cs_active,
	output logic            cs_rise,
	output logic            sck_fall,
	output logic [2:0]      bit_phase,
	output logic            byte_valid,
	output logic [7:0]      byte_data,
	output logic [2:0]      byte_index,
	output logic            wp_n_sync
);
	import flash_status_pkg::*;

	logic [3:0] meta_reg;
	logic [3:0] sync_reg;
	logic       sck_prev_reg;
	logic       cs_prev_reg;
	logic [6:0] shift_reg;
	logic [2:0] next_index_reg;
	logic       sck_rise;

	////////////////////////////////////////////////////////////////////////////
	// Every pin goes through two flops; only the second stage is ever read.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_reg[g] <= (g == 1 || g == 3);
					sync_reg[g] <= (g == 1 || g == 3);
				end else begin
					meta_reg[g] <= (g == 0) ? sck : (g == 1) ? cs_n : (g == 2) ? si : wp_n;
					sync_reg[g] <= meta_reg[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_prev_reg <= 1'b0;
			cs_prev_reg  <= 1'b1;
		end else begin
			sck_prev_reg <= sync_reg[0];
			cs_prev_reg  <= sync_reg[1];
		end
	end

	assign cs_active = !sync_reg[1];
	assign cs_rise   = sync_reg[1] && !cs_prev_reg;
	assign sck_rise  = cs_active && sync_reg[0] && !sck_prev_reg;
	assign sck_fall  = cs_active && !sync_reg[0] && sck_prev_reg;
	assign wp_n_sync = sync_reg[3];

	////////////////////////////////////////////////////////////////////////////
	// Bytes are assembled MSB first on rising edges of the serial clock.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg      <= 7'h00;
			bit_phase      <= 3'h0;
			next_index_reg <= 3'h0;
			byte_valid     <= 1'b0;
			byte_data      <= 8'h00;
			byte_index     <= 3'h0;
		end else begin
			byte_valid <= 1'b0;
			if (!cs_active) begin
				bit_phase      <= 3'h0;
				next_index_reg <= 3'h0;
			end else if (sck_rise) begin
				shift_reg <= {shift_reg[5:0], sync_reg[2]};
				bit_phase <= bit_phase + 3'h1;
				if (bit_phase == BIT_LAST) begin
					byte_valid <= 1'b1;
					byte_data  <= {shift_reg, sync_reg[2]};
					byte_index <= next_index_reg;
					if (next_index_reg != BYTE_CNT_MAX) begin
						next_index_reg <= next_index_reg + 3'h1;
					end
				end
			end
		end
	end

endmodule

// ### flash_status_write_gating.sv
`timescale 1ns/1ps
module flash_status_write_gating #(
	parameter logic [7:0] LATCH_CLEAR_OP = 8'h04,
	parameter logic [7:0] STATUS_READ_OP = 8'h05,
	parameter logic [7:0] SUSPEND_OP     = 8'h75,
	parameter logic [7:0] SOFT_RESET_OP  = 8'h99
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        sck,
	input  wire logic        cs_n,
	input  wire logic        si,
	input  wire logic        wp_n,
	output logic             so,
	output logic             so_oe,
	input  wire logic        four_byte_mode,
	input  wire logic        protect_bottom,
	input  wire logic        op_done,
	output logic             op_start,
	output logic [7:0]       op_code,
	output logic [31:0]      op_addr,
	output logic             suspend_req,
	output logic             soft_reset_req,
	output logic             busy_flag,
	output logic             write_latch,
	output logic [3:0]       protect_bits,
	output logic             four_line_enable,
	output logic             status_write_lock
);
	import flash_status_pkg::*;

	logic        rst_meta_reg;
	logic        rst_n;
	logic        cs_active;
	logic        cs_rise;
	logic        sck_fall;
	logic [2:0]  bit_phase;
	logic        byte_valid;
	logic [7:0]  byte_data;
	logic [2:0]  byte_index;
	logic        wp_n_sync;
	frame_t      frame_reg;
	logic [7:0]  cmd_reg;
	logic [2:0]  cnt_reg;
	logic [31:0] addr_reg;
	logic [7:0]  wdata_reg;
	logic [5:0]  nv_reg;
	logic        array_busy_reg;
	logic [7:0]  out_reg;
	logic [7:0]  status_word;
	logic        allowed;
	logic        exec;
	logic        addr4;
	logic [2:0]  need;
	logic [8:0]  block;
	logic [9:0]  pcount;
	logic        area_locked;
	logic        status_locked;
	logic        go;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	spi_front u_front (
		.clk        (clk),
		.rst_n      (rst_n),
		.sck        (sck),
		.cs_n       (cs_n),
		.si         (si),
		.wp_n       (wp_n),
		.cs_active  (cs_active),
		.cs_rise    (cs_rise),
		.sck_fall   (sck_fall),
		.bit_phase  (bit_phase),
		.byte_valid (byte_valid),
		.byte_data  (byte_data),
		.byte_index (byte_index),
		.wp_n_sync  (wp_n_sync)
	);

	assign status_word = {nv_reg, write_latch, busy_flag};
	assign protect_bits      = nv_reg[BIT_BP_HI-2:BIT_BP_LO-2];
	assign four_line_enable  = nv_reg[BIT_FOUR-2];
	assign status_write_lock = nv_reg[BIT_LOCK-2];

	////////////////////////////////////////////////////////////////////////////
	// Opcode admission is decided on the opcode byte, so a busy device drops a
	// whole frame rather than half-executing it.
	always_comb begin
		allowed = !busy_flag;
		if (byte_data == STATUS_READ_OP || byte_data == SOFT_RESET_OP) begin
			allowed = 1'b1;
		end
		if (byte_data == SUSPEND_OP && array_busy_reg) begin
			allowed = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_reg <= FR_IDLE;
			cmd_reg   <= 8'h00;
		end else begin
			unique case (frame_reg)
				FR_IDLE: if (cs_active) frame_reg <= FR_CMD;
				FR_CMD: begin
					if (cs_rise) begin
						frame_reg <= FR_IDLE;
					end else if (byte_valid && byte_index == 3'h0) begin
						cmd_reg <= byte_data;
						if (!allowed) begin
							frame_reg <= FR_DROP;
						end else if (byte_data == STATUS_READ_OP) begin
							frame_reg <= FR_READ;
						end
					end
				end
				FR_READ: if (cs_rise) frame_reg <= FR_IDLE;
				FR_DROP: if (cs_rise) frame_reg <= FR_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address bytes stop shifting once complete so trailing data cannot spoil them.
	assign addr4 = in_addr4_set(cmd_reg) || four_byte_mode;
	assign need  = in_array_set(cmd_reg) ? (addr4 ? ADDR_BYTES_4 : ADDR_BYTES_3) :
		(cmd_reg == OP_STATUS_WRITE) ? DATA_BYTES_1 : 3'h0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg   <= 3'h0;
			addr_reg  <= 32'h0000_0000;
			wdata_reg <= 8'h00;
		end else if (frame_reg == FR_IDLE) begin
			cnt_reg <= 3'h0;
		end else if (byte_valid && byte_index != 3'h0) begin
			if (cnt_reg != BYTE_CNT_MAX) cnt_reg <= cnt_reg + 3'h1;
			if (cnt_reg < need) addr_reg <= {addr_reg[23:0], byte_data};
			if (byte_index == 3'h1) wdata_reg <= byte_data;
		end
	end

	assign block  = addr4 ? addr_reg[BLOCK_LSB+8:BLOCK_LSB] : {1'b0, addr_reg[BLOCK_LSB+7:BLOCK_LSB]};
	assign pcount = protect_count(protect_bits);
	assign area_locked = protect_bottom ? ({1'b0, block} < pcount) :
		({1'b0, block} >= (BLOCK_TOTAL - pcount));
	assign status_locked = status_write_lock && !wp_n_sync;

	assign exec = cs_rise && frame_reg == FR_CMD;

	always_comb begin
		go = exec && in_we_set(cmd_reg) && write_latch && cnt_reg >= need;
		if (cmd_reg == OP_STATUS_WRITE && status_locked) go = 1'b0;
		if ((cmd_reg == OP_ERASE_ALL_A || cmd_reg == OP_ERASE_ALL_B) && protect_bits != 4'h0) begin
			go = 1'b0;
		end
		if (in_array_set(cmd_reg) && area_locked) go = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_flag      <= STATUS_RESET[BIT_BUSY];
			array_busy_reg <= 1'b0;
		end else if (busy_flag && op_done) begin
			busy_flag      <= 1'b0;
			array_busy_reg <= 1'b0;
		end else if (go) begin
			busy_flag      <= 1'b1;
			array_busy_reg <= in_array_set(cmd_reg) ||
				cmd_reg == OP_ERASE_ALL_A || cmd_reg == OP_ERASE_ALL_B;
		end
	end

	// The status write path is absent here on purpose: it must not touch the latch.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_latch <= STATUS_RESET[BIT_LATCH];
		end else if (busy_flag && op_done) begin
			write_latch <= 1'b0;
		end else if (exec && cmd_reg == OP_LATCH_SET) begin
			write_latch <= 1'b1;
		end else if (exec && cmd_reg == LATCH_CLEAR_OP) begin
			write_latch <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nv_reg <= NV_RESET;
		end else if (go && cmd_reg == OP_STATUS_WRITE) begin
			nv_reg <= wdata_reg[BIT_LOCK:BIT_BP_LO];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op_start       <= 1'b0;
			op_code        <= 8'h00;
			op_addr        <= 32'h0000_0000;
			suspend_req    <= 1'b0;
			soft_reset_req <= 1'b0;
		end else begin
			op_start       <= go;
			suspend_req    <= exec && cmd_reg == SUSPEND_OP && array_busy_reg && !op_done;
			soft_reset_req <= exec && cmd_reg == SOFT_RESET_OP;
			if (go) begin
				op_code <= cmd_reg;
				op_addr <= addr4 ? addr_reg : {8'h00, addr_reg[23:0]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Each byte boundary reloads the live word, so a poll sees busy drop mid-frame.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_reg <= 8'h00;
			so      <= 1'b0;
		end else if (frame_reg == FR_READ && sck_fall) begin
			if (bit_phase == 3'h0) begin
				so      <= status_word[7];
				out_reg <= {status_word[6:0], 1'b0};
			end else begin
				so      <= out_reg[7];
				out_reg <= {out_reg[6:0], 1'b0};
			end
		end
	end

	assign so_oe = frame_reg == FR_READ;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_busy_on_start: assert property (op_start |-> busy_flag)
		else $error("busy not set with operation start");
	a_busy_blocks: assert property (busy_flag && !op_done |=> !op_start)
		else $error("operation started while busy");
	a_busy_release: assert property (busy_flag && op_done |=> !busy_flag && !write_latch)
		else $error("completion did not clear busy and latch");
	a_latch_gate: assert property (op_start |-> $past(write_latch))
		else $error("gated operation started with latch low");
	a_latch_set: assert property (exec && cmd_reg == OP_LATCH_SET && !op_done |=> write_latch)
		else $error("latch set instruction ignored");
	a_latch_clear: assert property (exec && cmd_reg == LATCH_CLEAR_OP |=> !write_latch)
		else $error("latch clear instruction ignored");
	a_latch_status_write_cmd: assert property (exec && cmd_reg == OP_STATUS_WRITE && !op_done
		|=> write_latch == $past(write_latch))
		else $error("status write changed latch");
	a_lock_hold: assert property (status_locked |=> $stable(nv_reg))
		else $error("locked status word changed");
	a_erase_all: assert property (op_start && (op_code == OP_ERASE_ALL_A ||
		op_code == OP_ERASE_ALL_B) |-> $past(protect_bits) == 4'h0)
		else $error("whole erase started under protection");
	a_drop_state: assert property (exec && !write_latch && in_we_set(cmd_reg)
		|=> !busy_flag && $stable(nv_reg))
		else $error("ungated instruction changed state");

	c_status_write: cover property (op_start && op_code == OP_STATUS_WRITE);
	c_poll_busy: cover property (frame_reg == FR_READ && busy_flag ##[1:1000] !busy_flag);
	c_suspend: cover property (suspend_req);
	c_dropped: cover property (exec && in_we_set(cmd_reg) && !go);

endmodule

// ### flash_host_model.sv
`timescale 1ns/1ps
module flash_host_model (
	input  wire logic clk,
	output logic      sck,
	output logic      cs_n,
	output logic      si,
	input  wire logic so
);
	// The serial clock stands low between frames, as in mode 0.
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic half();
		repeat (8) @(posedge clk);
	endtask

	// Sends n bytes from the top of tx, MSB first, and returns every bit seen on so.
	task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
		rx = '0;
		@(posedge clk);
		cs_n <= 1'b0;
		for (int i = 0; i < n * 8; i++) begin
			si <= tx[63 - i];
			half();
			sck <= 1'b1;
			rx = {rx[62:0], so};
			half();
			sck <= 1'b0;
		end
		half();
		cs_n <= 1'b1;
		// A released data line must not keep looking like valid data.
		si <= ~si;
		repeat (8) @(posedge clk);
	endtask

	// Every write-gated instruction is preceded by its own latch-set frame.
	task automatic gated(input int n, input logic [63:0] tx, output logic [63:0] rx);
		frame(1, {8'h06, 56'h0}, rx);
		frame(n, tx, rx);
	endtask
endmodule

// ### flash_status_write_gating_bench.sv
`timescale 1ns/1ps
module flash_status_write_gating_bench;
	import flash_status_pkg::*;
	logic        clk, arst_n, sck, cs_n, si, wp_n, so, so_oe, op_done, ca, a4;
	logic        four_byte_mode, protect_bottom, op_start, suspend_req, soft_reset_req;
	logic        busy_flag, write_latch, four_line_enable, status_write_lock;
	logic [7:0]  op_code;
	logic [31:0] op_addr, a;
	logic [3:0]  protect_bits;
	logic [40:0] exp_q[$];
	logic [40:0] seen;
	logic [63:0] rx, tx;
	int          err_count, n_compared, n_susp, n_rst;

	flash_status_write_gating u_flash_status_write_gating (.clk, .arst_n, .sck, .cs_n, .si,
		.wp_n, .so, .so_oe, .four_byte_mode, .protect_bottom, .op_done, .op_start, .op_code,
		.op_addr, .suspend_req, .soft_reset_req, .busy_flag, .write_latch, .protect_bits,
		.four_line_enable, .status_write_lock);

	// A released output shows the inverse, so a read outside the enable cannot pass.
	flash_host_model u_flash_host_model (.clk, .sck, .cs_n, .si, .so (so_oe ? so : ~so));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check_val(input logic [31:0] got, input logic [31:0] want, input string what);
		n_compared++;
		if (got !== want) begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic read_status(input logic [7:0] want);
		u_flash_host_model.frame(4, {8'h05, 56'h0}, rx);
		check_val(rx[23:16], want, "status first byte");
		check_val(rx[7:0], want, "status repeat byte");
		check_val({status_write_lock, four_line_enable, protect_bits, write_latch, busy_flag},
			want, "status pins");
	endtask

	task automatic drop(input logic [63:0] tx, input int n, input bit latch);
		if (latch) u_flash_host_model.frame(1, {8'h06, 56'h0}, rx);
		u_flash_host_model.frame(n, tx, rx);
		check_val(busy_flag, 0, "refused op left busy");
		check_val(so_oe, 0, "output enabled after frame");
	endtask

	// The expected start is noted before the frame, since the pulse comes before it returns.
	task automatic start(input logic [63:0] tx, input int n, input logic c, input logic [31:0] ad);
		exp_q.push_back({c, tx[63:56], ad});
		u_flash_host_model.gated(n, tx, rx);
		check_val(busy_flag, 1, "busy after start");
	endtask

	task automatic finish();
		repeat (1 + $urandom_range(15)) @(posedge clk);
		op_done <= 1'b1;
		@(posedge clk);
		op_done <= 1'b0;
		repeat (2) @(posedge clk);
		check_val(busy_flag, 0, "busy after done");
		check_val(write_latch, 0, "latch after done");
		check_val(exp_q.size(), 0, "op never started");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(negedge clk) begin
		if (op_start === 1'b1) begin
			if (exp_q.size() == 0) begin
				check_val(1, 0, "op started unasked");
			end else begin
				seen = exp_q.pop_front();
				check_val(op_code, seen[39:32], "op code");
				if (seen[40]) check_val(op_addr, seen[31:0], "op address");
			end
		end
		if (suspend_req === 1'b1) n_susp++;
		if (soft_reset_req === 1'b1) n_rst++;
	end

	initial begin
		repeat (90000) @(posedge clk);
		check_val(1, 0, "run did not finish");
		give_verdict();
	end

	initial begin
		arst_n = 1'b0;
		wp_n = 1'b1;
		op_done = 1'b0;
		four_byte_mode = 1'b0;
		protect_bottom = 1'b0;
		void'($urandom(44548));
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (6) @(posedge clk);
		read_status(8'h00);
		drop({8'h02, 56'h0}, 4, 0);
		u_flash_host_model.frame(1, {8'h06, 56'h0}, rx);
		read_status(8'h02);
		u_flash_host_model.frame(1, {8'h04, 56'h0}, rx);
		read_status(8'h00);
		start({8'h01, 8'hfe, 48'h0}, 2, 0, 0);
		read_status(8'hff);
		u_flash_host_model.frame(1, {8'h04, 56'h0}, rx);
		u_flash_host_model.frame(2, {8'h01, 8'h00, 48'h0}, rx);
		u_flash_host_model.frame(1, {8'h75, 56'h0}, rx);
		read_status(8'hff);
		check_val(n_susp, 0, "suspend during status write");
		finish();
		read_status(8'hfc);
		@(posedge clk);
		wp_n <= 1'b0;
		drop({8'h01, 56'h0}, 2, 1);
		read_status(8'hfe);
		// A reset in mid-run returns every status bit to zero.
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (6) @(posedge clk);
		read_status(8'h00);
		@(posedge clk);
		wp_n <= 1'b1;
		start({8'h01, 8'h04, 48'h0}, 2, 0, 0);
		finish();
		read_status(8'h04);
		@(posedge clk);
		four_byte_mode <= 1'b1;
		drop({8'hd8, 32'h01ff0000, 24'h0}, 5, 1);
		drop({8'hc7, 56'h0}, 1, 1);
		@(posedge clk);
		protect_bottom <= 1'b1;
		drop({8'hd8, 32'h00000000, 24'h0}, 5, 1);
		start({8'hd8, 32'h01ff0000, 24'h0}, 5, 1, 32'h01ff0000);
		finish();
		start({8'h02, 32'h00100000, 24'h0}, 5, 1, 32'h00100000);
		u_flash_host_model.frame(1, {8'h75, 56'h0}, rx);
		u_flash_host_model.frame(1, {8'h99, 56'h0}, rx);
		check_val(n_susp, 1, "suspend during program");
		check_val(n_rst, 1, "reset during program");
		finish();
		start({8'h01, 56'h0}, 2, 0, 0);
		finish();
		start({8'hc7, 56'h0}, 1, 0, 0);
		finish();
		read_status(8'h00);
		// With no blocks protected, every gated code must start once its latch is set.
		for (int i = 0; i < WE_OPS_N; i++) begin
			a = $urandom() & 32'h00ffffff;
			ca = 1'b0;
			a4 = i[1];
			four_byte_mode <= a4;
			for (int j = 0; j < ARRAY_OPS_N; j++) ca |= (ARRAY_OPS[j] == WE_OPS[i]);
			for (int j = 0; j < ADDR4_OPS_N; j++) a4 |= (ADDR4_OPS[j] == WE_OPS[i]);
			// Three-byte addresses leave the top address byte out of the frame.
			tx = (ca && !a4) ? {WE_OPS[i], a[23:0], 32'h0} : {WE_OPS[i], a, 24'h0};
			if (i % 2 == 0) drop(tx, 5, 0);
			start(tx, 5, ca, a);
			finish();
		end
		give_verdict();
	end
endmodule
